// [bench/timer16_prescale_interval_tb_top.sv]
`timescale 1ns/1ps
module timer16_prescale_interval_tb_top;
  import tmr_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, irq, pin_a, pin_b;
  logic pin_o, pin_oe;
  int fail_count, samples_checked, irq_cnt, base, g, dv;

  tmr_top tmr_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer_in_a(pin_a), .shared_pin_b_i(pin_b),
    .shared_pin_b_o(pin_o), .shared_pin_b_oe(pin_oe),
    .compare_a_irq(irq));
  tmr_pins_model tmr_pins_model_inst (.aclk(aclk), .pin_b_o(pin_o),
    .pin_b_oe(pin_oe), .pin_a(pin_a), .pin_b_i(pin_b));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // gap in clocks between two compare pulses
  task automatic gap();
    int n;
    n = 0;
    @(posedge aclk);
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (irq !== 1'b1 && g < 3000);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    give_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    irq_cnt = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_DIR);
    chk("dir", d, 32'hff);
    rd(IDX_FMODE);
    chk("fmode", d, 32'h0);
    rd(IDX_CMP);
    chk("cmp", d, 32'hffff);
    wr(IDX_PRM, 32'hff);
    rd(IDX_PRM);
    chk("prm", d, 32'hf3);
    rd(16'h0010);
    chk("unmapped", {30'h0, resp}, RESP_SLVERR);
    wr(IDX_DIR, 32'h0);
    rd(IDX_DIR);
    chk("dir", d, 32'hf0);
    repeat (2) @(posedge aclk);
    chk("oe", pin_oe, 1'b1);
    wr(IDX_FMODE, 32'h2);
    repeat (2) @(posedge aclk);
    chk("oe analog", pin_oe, 1'b0);
    wr(IDX_FMODE, 32'h0);
    // one write: enable, level set and a single trigger in one-shot mode
    wr(IDX_TOC, 32'h69);
    rd(IDX_TOC);
    chk("toc", d, 32'h21);
    repeat (2) @(posedge aclk);
    chk("pin set", pin_o, 1'b1);
    wr(IDX_TOC, 32'h05);
    repeat (2) @(posedge aclk);
    chk("pin clr", pin_o, 1'b0);
    // clk, /4 and /256 count clocks with compare 3: period is four ticks
    for (int k = 0; k < 3; k++) begin
      wr(IDX_CRC, 32'h0);
      wr(IDX_CMP, 32'h3);
      wr(IDX_PRM, k);
      wr(IDX_MODE, 32'h3);
      dv = k == 0 ? 1 : k == 1 ? DIV_FAST : DIV_SLOW;
      gap();
      chk("period", g, 4 * dv);
      wr(IDX_MODE, 32'h0);
      rd(IDX_CNT);
      chk("cnt stop", d, 32'h0);
      rd(IDX_STAT);
      chk("ovf", d & 32'h1, 32'h0);
    end
    // input a back to input mode; its edges are the count clock
    wr(IDX_DIR, 32'hf);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_CMP, 32'h1);
      wr(IDX_PRM, k == 0 ? 32'h03 : k == 1 ? 32'h13 : 32'h33);
      base = irq_cnt;
      wr(IDX_MODE, 32'h3);
      tmr_pins_model_inst.pulses(4, 4);
      // a one-clock glitch must be filtered out
      tmr_pins_model_inst.pulses(1, 1);
      repeat (10) @(posedge aclk);
      chk("edges", irq_cnt - base, k == 2 ? 4 : 2);
      wr(IDX_MODE, 32'h0);
    end
    // pin rises while stopped: edge seen at enable
    wr(IDX_PRM, 32'h13);
    tmr_pins_model_inst.set_a(1'b1);
    repeat (4) @(posedge aclk);
    wr(IDX_MODE, 32'h1);
    repeat (10) @(posedge aclk);
    rd(IDX_CNT);
    chk("cnt enable", d, 32'h1);
    wr(IDX_MODE, 32'h0);
    // input b rising edge raises the event flag, a zero clears it
    wr(IDX_TOC, 32'h0);
    wr(IDX_PRM, 32'h40);
    wr(IDX_MODE, 32'h1);
    tmr_pins_model_inst.set_b(1'b1);
    repeat (6) @(posedge aclk);
    rd(IDX_STAT);
    chk("b edge", d & 32'h2, 32'h2);
    wr(IDX_STAT, 32'h1);
    rd(IDX_STAT);
    chk("b clear", d & 32'h2, 32'h0);
    wr(IDX_MODE, 32'h0);
    give_verdict();
  end
endmodule

// [bench/tmr_pins_model.sv]
`timescale 1ns/1ps
module tmr_pins_model (
  // clock
  input  wire logic aclk,
  // shared pin b from the timer
  input  wire logic pin_b_o,
  input  wire logic pin_b_oe,
  // pin levels seen by the timer
  output      logic pin_a,
  output      logic pin_b_i
);
  logic b_drv;

  initial begin
    pin_a = 1'b0;
    b_drv = 1'b0;
  end

  // timer drives the wire while enabled, source otherwise
  assign pin_b_i = pin_b_oe ? pin_b_o : b_drv;

  // width below two clocks breaks the pulse rule on purpose
  task automatic pulses(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      pin_a <= 1'b1;
      repeat (w) @(posedge aclk);
      pin_a <= 1'b0;
      repeat (w) @(posedge aclk);
    end
  endtask

  task automatic set_a(input logic v);
    @(posedge aclk);
    pin_a <= v;
  endtask

  task automatic set_b(input logic v);
    @(posedge aclk);
    b_drv <= v;
  endtask
endmodule

// [logic/tmr_pkg.sv]
package tmr_pkg;
  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_DIR    = 16'hff22;
  localparam logic [15:0] IDX_FMODE  = 16'hff23;
  localparam logic [15:0] IDX_MODE   = 16'hff60;
  localparam logic [15:0] IDX_PRM    = 16'hff61;
  localparam logic [15:0] IDX_CRC    = 16'hff62;
  localparam logic [15:0] IDX_TOC    = 16'hff63;
  localparam logic [15:0] IDX_CMP    = 16'hff64;
  localparam logic [15:0] IDX_CNT    = 16'hff65;
  localparam logic [15:0] IDX_STAT   = 16'hff66;
  localparam int          AXI_AW     = 18;
  // reset values
  localparam logic [7:0]  RST_DIR    = 8'hff;
  localparam logic [7:0]  RST_FMODE  = 8'h00;
  localparam logic [7:0]  RST_PRM    = 8'h00;
  localparam logic [15:0] RST_CMP    = 16'hffff;
  localparam logic [3:0]  DIR_FIXED  = 4'hf;
  // output control bit positions
  localparam int TOC_OE    = 0;
  localparam int TOC_INVA  = 1;
  localparam int TOC_LVC   = 2;
  localparam int TOC_LVS   = 3;
  localparam int TOC_INVB  = 4;
  localparam int TOC_OSEN  = 5;
  localparam int TOC_OSTRG = 6;
  // mode control bit positions
  localparam int MODE_RUN  = 0;
  localparam int MODE_INTV = 1;
  // prescaler dividers
  localparam int DIV_SLOW  = 256;
  localparam int DIV_FAST  = 4;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  dir;
    logic [7:0]  fmode;
    logic [7:0]  prm;
    logic [2:0]  crc;
    logic [1:0]  mode;
    logic [7:0]  toc;
    logic        out_ff;
    logic [15:0] cmp;
    logic [15:0] cnt;
    logic        ovf;
    logic        inb_ev;
    logic        irq;
    logic [7:0]  div;
    logic [1:0]  sa;
    logic [1:0]  sb;
    logic        la;
    logic        lb;
    logic        pin_o;
    logic        pin_oe;
  } tmr_state_s;
endpackage

// [logic/tmr_top.sv]
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
//
// Contract
// - reads of output level set and clear bits return zero.
// - one-shot trigger bit clears itself; reads return zero.
// - prescaler bits 7:6 select input b edge: fall, rise, both.
// - prescaler bits 5:4 select input a edge: fall, rise, both.
// - bits 1:0 pick count clock: clk, /4, /256, input a edge.
// - edge reported at enable when pin differs from held level; input b edge comes only after two new count-clock samples.
// - edge accepted only after new level sampled twice.
// - shared pin is either input b or timer output.
// - direction 0 enables output buffer; upper four bits read 1.
// - mode-control 1 selects analog; timer use needs 0.
// - interval match clears counter, keeps counting, raises interrupt.
// - interval period is compare plus one count clocks.
// - interval mode sets overflow only when compare is FFFFH.
// - compare below count lets counter overflow then restart.
// - level pair: 00 none, 01 clear flop, 10 set flop.
module tmr_top
  import tmr_pkg::*;
#(
  parameter int ADDR_W = AXI_AW
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  // timer pins
  input  wire logic              timer_in_a,
  input  wire logic              shared_pin_b_i,
  output      logic              shared_pin_b_o,
  output      logic              shared_pin_b_oe,
  // event
  output      logic              compare_a_irq
);

  if (ADDR_W < AXI_AW) begin : g_chk
    $error("ADDR_W too small for register map");
  end

  tmr_state_s s;
  tmr_state_s n;
  logic       ina_g;
  logic       inb_g;
  logic       a_acc;
  logic       b_acc;
  logic       a_hit;
  logic       cnt_tick;
  logic       match;
  logic       wr_go;
  logic [15:0] widx;
  logic [15:0] ridx;

  function automatic logic edge_hit(input logic [1:0] es,
                                    input logic       rise,
                                    input logic       fall);
    case (es)
      2'b00:   edge_hit = fall;
      2'b01:   edge_hit = rise;
      2'b11:   edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic mapped(input logic [15:0] idx);
    mapped = idx == IDX_DIR || idx == IDX_FMODE || idx == IDX_MODE ||
             idx == IDX_PRM || idx == IDX_CRC || idx == IDX_TOC ||
             idx == IDX_CMP || idx == IDX_CNT || idx == IDX_STAT;
  endfunction

  assign widx = awaddr[AXI_AW-1:2];
  assign ridx = araddr[AXI_AW-1:2];

  always_comb begin
    n = s;
    ina_g = 1'b0;
    inb_g = 1'b0;
    a_acc = 1'b0;
    b_acc = 1'b0;
    a_hit = 1'b0;
    cnt_tick = 1'b0;
    match = 1'b0;
    wr_go = 1'b0;
    n.awready = 1'b0;
    n.wready = 1'b0;
    n.arready = 1'b0;
    n.irq = 1'b0;
    n.div = s.div + 8'h01;
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    // address and data taken together; response a cycle after
    if (awvalid && wvalid && !s.awready && !s.bvalid) begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (s.awready) begin
      n.bvalid = 1'b1;
      n.bresp = mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      wr_go = mapped(widx) && wstrb[0];
    end
    if (arvalid && !s.arready && !s.rvalid) begin
      n.arready = 1'b1;
    end
    if (s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      case (ridx)
        IDX_DIR:   n.rdata = {24'h000000, s.dir};
        IDX_FMODE: n.rdata = {24'h000000, s.fmode};
        IDX_MODE:  n.rdata = {30'h00000000, s.mode};
        IDX_PRM:   n.rdata = {24'h000000, s.prm};
        IDX_CRC:   n.rdata = {29'h00000000, s.crc};
        // level pair and trigger always read zero
        IDX_TOC:   n.rdata = {24'h000000, s.toc & 8'h33};
        IDX_CMP:   n.rdata = {16'h0000, s.cmp};
        IDX_CNT:   n.rdata = {16'h0000, s.cnt};
        IDX_STAT:  n.rdata = {30'h00000000, s.inb_ev, s.ovf};
        default:   n.rdata = 32'h00000000;
      endcase
    end

    // register writes
    if (wr_go) begin
      case (widx)
        IDX_DIR:   n.dir = {DIR_FIXED, wdata[3:0]};
        IDX_FMODE: n.fmode = wdata[7:0];
        IDX_MODE:  n.mode = wdata[1:0];
        IDX_PRM:   n.prm = {wdata[7:4], 2'b00, wdata[1:0]};
        IDX_CRC:   n.crc = wdata[2:0];
        IDX_TOC: begin
          // trigger is not stored so it reads zero afterwards
          n.toc = {2'b00, wdata[5:4], 2'b00, wdata[1:0]};
          case (wdata[TOC_LVS:TOC_LVC])
            2'b10:   n.out_ff = 1'b1;
            2'b01:   n.out_ff = 1'b0;
            default: n.out_ff = s.out_ff;
          endcase
        end
        IDX_CMP:   n.cmp = wdata[15:0];
        IDX_STAT: begin
          n.ovf = s.ovf & wdata[0];
          n.inb_ev = s.inb_ev & wdata[1];
        end
        default:   n.cmp = s.cmp;
      endcase
    end

    // pin routing: analog or output use blocks the timer inputs
    ina_g = timer_in_a & s.dir[0] & ~s.fmode[0];
    // buffer stays on one cycle after a direction change
    inb_g = shared_pin_b_i & s.dir[1] & ~s.fmode[1] &
            ~s.toc[TOC_OE] & ~s.pin_oe;

    // input a sampled every clock; held level frozen while stopped
    n.sa = {s.sa[0], ina_g};
    a_acc = s.mode[MODE_RUN] && s.sa[1] == s.sa[0] &&
            s.sa[0] != s.la;
    if (a_acc) begin
      n.la = s.sa[0];
    end
    a_hit = edge_hit(s.prm[5:4], a_acc & s.sa[0],
                     a_acc & ~s.sa[0]);

    case (s.prm[1:0])
      2'b00:   cnt_tick = 1'b1;
      2'b01:   cnt_tick = s.div[1:0] == 2'(DIV_FAST - 1);
      2'b10:   cnt_tick = s.div == 8'(DIV_SLOW - 1);
      default: cnt_tick = a_hit;
    endcase
    cnt_tick = cnt_tick & s.mode[MODE_RUN];

    // input b is filtered at the count clock rate
    if (cnt_tick) begin
      n.sb = {s.sb[0], inb_g};
    end
    b_acc = cnt_tick && s.sb[1] == s.sb[0] && s.sb[0] != s.lb;
    if (b_acc) begin
      n.lb = s.sb[0];
    end
    if (edge_hit(s.prm[7:6], b_acc & s.sb[0], b_acc & ~s.sb[0])) begin
      n.inb_ev = 1'b1;
    end

    match = s.mode[MODE_INTV] && s.cnt == s.cmp;
    if (!s.mode[MODE_RUN]) begin
      n.cnt = 16'h0000;
    end else if (cnt_tick) begin
      if (match) begin
        n.cnt = 16'h0000;
        n.irq = 1'b1;
        // a level write in the same cycle wins over the toggle
        if (s.toc[TOC_INVA] &&
            !(wr_go && widx == IDX_TOC && ^wdata[TOC_LVS:TOC_LVC])) begin
          n.out_ff = ~s.out_ff;
        end
      end else begin
        // a compare below the count is passed by wrapping
        n.cnt = s.cnt + 16'h0001;
      end
      if (s.cnt == 16'hffff &&
          (!s.mode[MODE_INTV] || s.cmp == 16'hffff)) begin
        n.ovf = 1'b1;
      end
    end

    n.pin_oe = ~s.dir[1] & ~s.fmode[1];
    n.pin_o = s.toc[TOC_OE] & n.out_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.dir <= RST_DIR;
      s.fmode <= RST_FMODE;
      s.prm <= RST_PRM;
      s.cmp <= RST_CMP;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign shared_pin_b_o = s.pin_o;
  assign shared_pin_b_oe = s.pin_oe;
  assign compare_a_irq = s.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TOC_LVL_ZERO: assert property (
    s.arready && ridx == IDX_TOC |=> rdata[TOC_LVS:TOC_LVC] == 2'b00)
    else $error("level bits read nonzero");
  AST_TRIG_ZERO: assert property (
    s.arready && ridx == IDX_TOC |=> !rdata[TOC_OSTRG])
    else $error("trigger bit read nonzero");
  AST_B_FALL_ONLY: assert property (
    b_acc && s.sb[0] && s.prm[7:6] == 2'b00 && !s.inb_ev && !wr_go
    |=> !s.inb_ev)
    else $error("rising b edge taken in falling mode");
  AST_A_FALL_ONLY: assert property (
    a_acc && s.sa[0] && s.prm[5:4] == 2'b00 |-> !a_hit)
    else $error("rising a edge taken in falling mode");
  AST_DIV4_GAP: assert property (
    cnt_tick && s.prm[1:0] == 2'b01 |=> !cnt_tick [*3])
    else $error("divide by four ticks too close");
  AST_EDGE_AT_START: assert property (
    $rose(s.mode[MODE_RUN]) && s.sa == 2'b11 && !s.la &&
    s.prm[5:4] == 2'b01 && s.prm[1:0] == 2'b11 |-> cnt_tick)
    else $error("edge at enable missed");
  AST_TWO_SAMPLES: assert property (
    a_acc |-> s.sa[0] == $past(ina_g) && s.sa[0] == $past(ina_g, 2))
    else $error("edge accepted without two samples");
  AST_PIN_EXCL: assert property (
    s.pin_oe |-> !inb_g)
    else $error("shared pin used as input while driven");
  AST_DIR_OFF: assert property (
    s.dir[1] |=> !shared_pin_b_oe && s.dir[7:4] == DIR_FIXED)
    else $error("buffer on in input mode");
  AST_ANALOG_OFF: assert property (
    s.fmode[1] |=> !shared_pin_b_oe)
    else $error("buffer on in analog mode");
  AST_MATCH_CLEAR: assert property (
    cnt_tick && match |=> s.cnt == 16'h0000 && compare_a_irq)
    else $error("match did not clear and interrupt");
  AST_OVF_CAUSE: assert property (
    $rose(s.ovf) |-> $past(s.cnt) == 16'hffff &&
    (!$past(s.mode[MODE_INTV]) || $past(s.cmp) == 16'hffff))
    else $error("overflow set without cause");
  AST_LVL_SET: assert property (
    wr_go && widx == IDX_TOC && wdata[TOC_LVS:TOC_LVC] == 2'b10
    |=> s.out_ff)
    else $error("level set failed");
  AST_STOP_ZERO: assert property (
    !s.mode[MODE_RUN] |=> s.cnt == 16'h0000)
    else $error("counter nonzero while stopped");

  COV_IRQ: cover property (compare_a_irq ##[1:300] compare_a_irq);
  COV_OVF: cover property ($rose(s.ovf));
  COV_EXT: cover property (cnt_tick && s.prm[1:0] == 2'b11);
  COV_BEV: cover property ($rose(s.inb_ev));

endmodule
